/* File: verilog/sfc_ctrl.sv */
// Host controller driving a strobed asynchronous FIFO through its pins
`timescale 1ns/10ps
module sfc_ctrl
    import sfc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // User side: words to write
    input  wire logic [WORD_W-1:0] userWrData,
    input  wire logic              userWrValid,
    output logic                   userWrReady,
    // User side: read, replay and clear requests
    input  wire logic              userRdReq,
    output logic      [WORD_W-1:0] userRdData,
    output logic                   userRdValid,
    input  wire logic              userReplayReq,
    input  wire logic              userClearReq,
    output logic                   userBusy,
    output logic                   userEmpty,
    output logic                   userFull,
    output logic                   userHalf,
    // Device pins
    output logic                   writeStrobe_n,
    output logic                   readStrobe_n,
    output logic      [WORD_W-1:0] write_word,
    input  wire logic [WORD_W-1:0] read_word,
    output logic                   master_clear_n,
    output logic                   first_load_or_replay_n,
    output logic                   chain_input_n,
    input  wire logic              empty_flag_n,
    input  wire logic              full_flag_n,
    input  wire logic              chain_out_half_n
);
    // ======================================================================
    // Pin synchronisers
    logic [1:0]        efSync;         // Empty flag sync chain
    logic [1:0]        ffSync;         // Full flag sync chain
    logic [1:0]        hfSync;         // Half flag sync chain
    logic [WORD_W-1:0] rdSync1;        // Read data first stage
    logic [WORD_W-1:0] rdSync2;        // Read data second stage
    wire               devEmpty = !efSync[1];
    wire               devFull  = !ffSync[1];
    // Two stages before any logic reads a pin
    always_ff @(posedge sys_clk) begin
        efSync  <= {efSync[0], empty_flag_n};
        ffSync  <= {ffSync[0], full_flag_n};
        hfSync  <= {hfSync[0], chain_out_half_n};
        rdSync1 <= read_word;
        rdSync2 <= rdSync1;
    end

    // ======================================================================
    // Staging FIFO in the write path
    logic [WORD_W-1:0] stageData;      // Word at FIFO head
    logic              stageValid;     // Head word present
    logic              stagePop;       // Head word taken
    sfc_stage_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) uStage (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .inData   (userWrData),
        .inValid  (userWrValid),
        .inReady  (userWrReady),
        .outData  (stageData),
        .outValid (stageValid),
        .outReady (stagePop)
    );

    // ======================================================================
    // Sequencer
    sfc_state_t        state;          // Current step
    sfc_state_t        next_state;     // Next step
    logic [CNT_W-1:0]  timer;          // Cycles left in step
    logic [CNT_W-1:0]  next_timer;     // Next timer value
    logic              rdPending;      // Read request latched
    logic              rpPending;      // Replay request latched
    logic              clPending;      // Clear request latched
    wire               timerDone = (timer == CNT_ZERO);
    // Writes only when the device is not full, reads only when not empty
    wire               canWrite  = stageValid && !devFull;            // [R3] [R21]
    wire               canRead   = rdPending && !devEmpty;            // [R1] [R13] [R21]
    assign stagePop = (state == SFC_WR_LOW) && timerDone;             // Word leaves on rising strobe

    // Next step selection
    always_comb begin
        next_state = state;
        next_timer = timerDone ? CNT_ZERO : timer - CNT_ONE;
        case (state)
            SFC_CLEAR: begin                                          // [R14] [R15]
                if (timerDone) begin
                    next_state = SFC_CLEAR_REC;
                    next_timer = CNT_W'(CLEAR_CYC);
                end
            end
            SFC_CLEAR_REC: begin
                if (timerDone) next_state = SFC_IDLE;
            end
            SFC_IDLE: begin
                if (clPending) begin
                    next_state = SFC_CLEAR;
                    next_timer = CNT_W'(CLEAR_CYC);
                end else if (rpPending) begin                         // [R7]
                    next_state = SFC_RP_LOW;
                    next_timer = CNT_W'(STROBE_CYC);
                end else if (canRead) begin
                    next_state = SFC_RD_LOW;
                    next_timer = CNT_W'(STROBE_CYC);
                end else if (canWrite) begin
                    next_state = SFC_WR_LOW;
                    next_timer = CNT_W'(STROBE_CYC);
                end
            end
            SFC_WR_LOW: begin                                         // [R16]
                if (timerDone) begin
                    next_state = SFC_WR_HIGH;
                    next_timer = CNT_W'(HIGH_CYC + SYNC_CYC);
                end
            end
            SFC_RD_LOW: begin                                         // [R11] [R12]
                if (timerDone) begin
                    next_state = SFC_RD_HIGH;
                    next_timer = CNT_W'(HIGH_CYC + SYNC_CYC);
                end
            end
            SFC_RP_LOW: begin                                         // [R6]
                if (timerDone) begin
                    next_state = SFC_RP_HIGH;
                    next_timer = CNT_W'(STROBE_CYC + SYNC_CYC);
                end
            end
            SFC_WR_HIGH, SFC_RD_HIGH, SFC_RP_HIGH: begin             // Flags settle, [R9]
                if (timerDone) next_state = SFC_IDLE;
            end
            default: begin
                next_state = SFC_CLEAR;
                next_timer = CNT_W'(CLEAR_CYC);
            end
        endcase
    end

    // State and request latches
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state     <= SFC_CLEAR;                                   // [R15]
            timer     <= CNT_W'(CLEAR_CYC);
            rdPending <= 1'b0;
            rpPending <= 1'b0;
            clPending <= 1'b0;
        end else begin
            state     <= next_state;
            timer     <= next_timer;
            // Set wins over clear on each latch
            rdPending <= userRdReq || (rdPending && !(state == SFC_IDLE && next_state == SFC_RD_LOW));
            rpPending <= userReplayReq || (rpPending && next_state != SFC_RP_LOW);
            clPending <= userClearReq || (clPending && next_state != SFC_CLEAR);
        end
    end

    // ======================================================================
    // Pin and user outputs, all registered
    // Bus word caught on the last low edge reaches the sync end here
    wire sampleNow = (state == SFC_RD_HIGH) && (timer == CNT_W'(HIGH_CYC + SYNC_CYC) - CNT_ONE);
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            writeStrobe_n          <= 1'b1;
            readStrobe_n           <= 1'b1;
            write_word             <= '0;
            master_clear_n         <= 1'b0;
            first_load_or_replay_n <= 1'b1;
            chain_input_n          <= 1'b0;
            userRdData             <= '0;
            userRdValid            <= 1'b0;
            userBusy               <= 1'b1;
            userEmpty              <= 1'b1;
            userFull               <= 1'b0;
            userHalf               <= 1'b0;
        end else begin
            writeStrobe_n          <= !(next_state == SFC_WR_LOW);
            readStrobe_n           <= !(next_state == SFC_RD_LOW);
            master_clear_n         <= !(next_state == SFC_CLEAR);
            first_load_or_replay_n <= !(next_state == SFC_RP_LOW);   // [R5]
            chain_input_n          <= 1'b0;                           // [R17] [R20]
            if (state == SFC_IDLE && next_state == SFC_WR_LOW) write_word <= stageData;
            userRdValid            <= sampleNow;
            if (sampleNow) userRdData <= rdSync2;                     // [R10]
            userBusy               <= (next_state != SFC_IDLE);
            userEmpty              <= devEmpty;                       // [R2]
            userFull               <= devFull;                        // [R4] [R8]
            userHalf               <= !hfSync[1];                     // [R18] [R19]
        end
    end
endmodule

/* File: verilog/sfc_pkg.sv */
// Constants shared by the strobed FIFO controller and its buffer
// ==========================================================================
// What the device does
// [R1] Empty flag low: reads are ignored
// [R2] Empty with read low: write flows through
// [R3] Full flag low: writes are ignored
// [R4] Full with write low: read frees write
// [R5] First-load input low on first device
// [R6] Replay pulse rewinds read pointer only
// [R7] Both strobes high during replay pulse
// [R8] Replay only before depth writes occur
// [R9] Half flag updated after replay
// [R10] Read data floats when strobe high
// [R11] Read falling edge drives next word
// [R12] Last read: empty falls, data stays
// [R13] Read while empty keeps read pointer
// [R14] Clear resets pointers and flags
// [R15] Clear after power-up, strobes held high
// [R16] Write stores word on rising strobe
// [R17] Chain input grounded for standalone
// [R18] Past half, next write lowers half flag
// [R19] Half flag rises back at exactly half
// [R20] Chain output pulses at last location
// [R21] Pointers advance only when flags allow
// [R22] Pointers wrap as circular buffer
package sfc_pkg;
    localparam int WORD_W       = 9;       // Data word width
    localparam int FIFO_DEPTH   = 4;       // Staging FIFO depth
    localparam int CLK_MHZ      = 20;      // System clock rate
    localparam int T_STROBE_NS  = 50;      // Strobe low time, least
    localparam int T_HIGH_NS    = 15;      // Strobe high time, least
    localparam int T_CLEAR_NS   = 65;      // Clear low and recovery time
    localparam int T_ACCESS_NS  = 50;      // Read access time, most
    localparam int STROBE_CYC   = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int HIGH_CYC     = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int CLEAR_CYC    = (T_CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC   = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC     = 2;       // Pin synchroniser stages
    localparam int CNT_W        = 4;       // Timing counter width
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    // Controller sequence states
    typedef enum logic [3:0] {
        SFC_CLEAR, SFC_CLEAR_REC, SFC_IDLE, SFC_WR_LOW, SFC_WR_HIGH,
        SFC_RD_LOW, SFC_RD_HIGH, SFC_RP_LOW, SFC_RP_HIGH
    } sfc_state_t;
endpackage

/* File: verilog/sfc_stage_fifo.sv */
// Small parameterised staging FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sfc_stage_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];     // Storage array
    logic [PW-1:0]    wrPtr;           // Fill pointer
    logic [PW-1:0]    rdPtr;           // Drain pointer
    logic [PW:0]      count;           // Words held
    logic [PW:0]      nextCount;       // Words held after this edge
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;
    assign nextCount = count + (PW+1)'(doPush) - (PW+1)'(doPop);
    assign outValid  = (count != '0);
    assign outData   = mem[rdPtr];
    // Pointer and count update; ready is a flop so the user port is clean
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wrPtr   <= '0;
            rdPtr   <= '0;
            count   <= '0;
            inReady <= 1'b0;           // No room offered during reset
        end else begin
            if (doPush) begin
                mem[wrPtr] <= inData;
                wrPtr      <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count   <= nextCount;
            inReady <= (nextCount < (PW+1)'(DEPTH)); // Room after this edge
        end
    end
endmodule

/* File: tb/sfc_ctrl_properties.sv */
// Pin-level checks of the strobed FIFO controller
`timescale 1ns/10ps
module sfc_ctrl_properties
    import sfc_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              userRdValid,
    input wire logic              userEmpty,
    input wire logic              userFull,
    input wire logic              writeStrobe_n,
    input wire logic              readStrobe_n,
    input wire logic [WORD_W-1:0] write_word,
    input wire logic              master_clear_n,
    input wire logic              first_load_or_replay_n,
    input wire logic              chain_input_n
);
    // ==========================================
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_CLEAR_FIRST: assert property ($rose(rstn) |-> !master_clear_n)
        else $error("no device clear after reset");
    AST_STROBES_IN_CLEAR: assert property (!master_clear_n |-> writeStrobe_n && readStrobe_n)
        else $error("strobe low during clear");
    AST_STROBES_IN_REPLAY: assert property (!first_load_or_replay_n |-> writeStrobe_n && readStrobe_n)
        else $error("strobe low during replay");
    AST_CHAIN_GROUNDED: assert property (chain_input_n == 1'b0)
        else $error("chain input not grounded");
    AST_NO_READ_EMPTY: assert property ($fell(readStrobe_n) |-> !$past(userEmpty))
        else $error("read strobe while empty");
    AST_NO_WRITE_FULL: assert property ($fell(writeStrobe_n) |-> !$past(userFull))
        else $error("write strobe while full");
    AST_READ_WIDTH: assert property ($fell(readStrobe_n) |-> ##1 !readStrobe_n ##1 readStrobe_n)
        else $error("read strobe width wrong");
    AST_WRITE_HOLD: assert property ($fell(writeStrobe_n) |-> ##1 (!writeStrobe_n && $stable(write_word)) ##1 writeStrobe_n)
        else $error("write strobe or word unstable");
    AST_READ_ANSWER: assert property ($fell(readStrobe_n) |-> ##[2:8] userRdValid)
        else $error("read word never delivered");
    AST_STROBE_GAP: assert property ($rose(readStrobe_n) || $rose(writeStrobe_n) |-> (readStrobe_n && writeStrobe_n)[*4])
        else $error("strobe gap too short");
endmodule

/* File: tb/sfc_dev_model.sv */
// Behavioural strobed FIFO device driven by the controller
`timescale 1ns/10ps
module sfc_dev_model #(
    parameter int DEPTH = 8
) (
    input  wire logic       writeStrobe_n,
    input  wire logic       readStrobe_n,
    input  wire logic [8:0] write_word,
    output logic      [8:0] read_word,
    input  wire logic       master_clear_n,
    input  wire logic       first_load_or_replay_n,
    input  wire logic       chain_input_n,
    output logic            empty_flag_n,
    output logic            full_flag_n,
    output logic            chain_out_half_n
);
    logic [8:0] mem [DEPTH];   // Storage
    logic [8:0] qOut = 9'h000; // Last word driven
    int         rp = 0;        // Read pointer
    int         wp = 0;        // Write pointer
    int         cnt = 0;       // Stored words
    bit         drv = 0;       // Outputs enabled
    bit         wrArm = 0;     // Write cycle started
    // Flags from the word count
    assign empty_flag_n = (cnt != 0);
    assign full_flag_n = (cnt != DEPTH);
    assign chain_out_half_n = !(cnt > DEPTH / 2);
    // Released bus shows the inverse of the last word
    assign read_word = drv ? qOut : ~qOut;
    // Clear
    always @(negedge master_clear_n) begin
        {rp, wp, cnt, drv} = '0;
    end
    // Read cycle
    always @(negedge readStrobe_n) begin
        if (master_clear_n && cnt != 0) begin
            qOut = mem[rp];
            drv = 1;
            rp = (rp + 1) % DEPTH;
            cnt--;
        end
    end
    always @(posedge readStrobe_n) drv = 0;
    // Write cycle
    always @(negedge writeStrobe_n) wrArm = master_clear_n && cnt != DEPTH;
    always @(posedge writeStrobe_n) begin
        if (wrArm) begin
            mem[wp] = write_word;
            wp = (wp + 1) % DEPTH;
            cnt++;
        end
        wrArm = 0;
    end
    // Replay rewinds only the read side; grounded chain input means standalone
    always @(negedge first_load_or_replay_n) begin
        if (!chain_input_n && master_clear_n) begin
            rp = 0;
            cnt = wp;
        end
    end
endmodule

/* File: tb/sfc_ctrl_bench.sv */
// Self-checking bench for the strobed FIFO controller
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module sfc_ctrl_bench
    import sfc_pkg::*;
;
    localparam int DEV_DEPTH = 8; // Shortened device depth
    logic sys_clk, rstn, userWrValid, userRdReq, userReplayReq, userClearReq, userWrReady, userRdValid;
    logic userBusy, userEmpty, userFull, userHalf, writeStrobe_n, readStrobe_n, master_clear_n;
    logic first_load_or_replay_n, chain_input_n, empty_flag_n, full_flag_n, chain_out_half_n;
    logic [WORD_W-1:0] userWrData, userRdData, write_word, read_word;
    logic [WORD_W-1:0] hist [$]; // Words written since clear
    int                compares = 0, miscompares = 0, rIdx = 0;
    bit                got;
    sfc_ctrl dut (.sys_clk, .rstn, .userWrData, .userWrValid, .userWrReady, .userRdReq, .userRdData,
        .userRdValid, .userReplayReq, .userClearReq, .userBusy, .userEmpty, .userFull, .userHalf,
        .writeStrobe_n, .readStrobe_n, .write_word, .read_word, .master_clear_n, .first_load_or_replay_n,
        .chain_input_n, .empty_flag_n, .full_flag_n, .chain_out_half_n);
    sfc_dev_model #(.DEPTH(DEV_DEPTH)) dev (.writeStrobe_n, .readStrobe_n, .write_word, .read_word,
        .master_clear_n, .first_load_or_replay_n, .chain_input_n, .empty_flag_n, .full_flag_n,
        .chain_out_half_n);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    task automatic put(input logic [WORD_W-1:0] d);
        @(negedge sys_clk);
        userWrData = d;
        userWrValid = 1'b1;
        hist.push_back(d);
        while (userWrReady !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        userWrValid = 1'b0;
    endtask
    task automatic rd(input bit req, output bit ok);
        if (req) pulse(userRdReq);
        ok = 0;
        for (int n = 0; n < 80 && !ok; n++) begin
            @(negedge sys_clk);
            ok = (userRdValid === 1'b1);
        end
        if (ok) begin
            `CHK(userRdData, hist[rIdx])
            rIdx++;
        end
    endtask
    task automatic settle;
        int q;
        q = 0;
        for (int n = 0; n < 400 && q < 8; n++) begin
            @(negedge sys_clk);
            q = (userBusy === 1'b0) ? q + 1 : 0;
        end
    endtask
    task automatic flags;
        int c;
        settle();
        c = hist.size() - rIdx;
        c = (c > DEV_DEPTH) ? DEV_DEPTH : c;
        `CHK(userEmpty, logic'(c == 0))
        `CHK(userFull, logic'(c == DEV_DEPTH))
        `CHK(userHalf, logic'(c > DEV_DEPTH / 2))
    endtask
    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
    initial begin
        {rstn, userWrValid, userRdReq, userReplayReq, userClearReq} = '0;
        userWrData = '0;
        void'($urandom(98010));
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        flags();
        for (int i = 0; i < DEV_DEPTH + FIFO_DEPTH; i++) put(WORD_W'($urandom));
        settle();
        `CHK(userWrReady, 1'b0)
        flags();
        while (hist.size() > rIdx) begin
            rd(1, got);
            flags();
        end
        rd(1, got);
        `CHK(got, 1'b0)
        put(WORD_W'($urandom));
        rd(0, got);
        `CHK(got, 1'b1)
        put(WORD_W'($urandom));
        put(WORD_W'($urandom));
        settle();
        pulse(userClearReq);
        hist.delete();
        rIdx = 0;
        flags();
        repeat (5) put(WORD_W'($urandom));
        repeat (5) rd(1, got);
        flags();
        pulse(userReplayReq);
        rIdx = 0;
        flags();
        repeat (5) rd(1, got);
        flags();
        complete_run();
    end
endmodule
bind sfc_ctrl sfc_ctrl_properties chk (.sys_clk, .rstn, .userRdValid, .userEmpty, .userFull, .writeStrobe_n,
    .readStrobe_n, .write_word, .master_clear_n, .first_load_or_replay_n, .chain_input_n);
